/* src/fds_top.sv */
// fds_top.sv: floppy data separator, clock recovery and data split
`timescale 1ns/1ps
`default_nettype none
`include "fds_defs.svh"

module fds_top
    import fds_pkg::*;
(
    input  wire logic i_clk,
    input  wire logic i_reset,
    input  wire logic i_reference_clock_in,
    input  wire logic i_divider_select_0,
    input  wire logic i_divider_select_1,
    input  wire logic i_disk_pulse_in_n,
    output logic      o_recovered_clock_out,
    output logic      o_separated_data_out
);

    logic       ref_prev_r;
    logic       pulse_prev_r;
    fds_phase_t phase_r;
    fds_phase_t phase_nxt;
    fds_corr_t  st_r;
    fds_corr_t  st_nxt;
    fds_corr_t  lt_r;
    fds_corr_t  lt_nxt;
    fds_corr_t  acc_r;
    fds_corr_t  acc_nxt;
    logic       data_flag_r;
    logic       rclk_r;
    logic       sdata_r;

    logic       ref_tick;
    logic       int_tick;
    logic       pulse_edge;
    fds_half_e  half;
    fds_phase_t center;
    fds_len_t   err;
    fds_len_t   err_half;
    fds_corr_t  st_meas;
    fds_len_t   len_raw;
    fds_len_t   len;
    logic       cell_end;
    logic       err_late;
    logic       err_early;
    logic       acc_up;
    logic       acc_dn;

    ////////////////////////////////////////////////////////////////////////
    // reference edge and internal clock divider
    assign ref_tick = i_reference_clock_in && !ref_prev_r;

    fds_divider u_divider (
        .i_clk      (i_clk),
        .i_reset    (i_reset),
        .i_ref_tick (ref_tick),
        .i_div_sel  ({i_divider_select_1, i_divider_select_0}),
        .o_int_tick (int_tick)
    );

    ////////////////////////////////////////////////////////////////////////
    // pulse leading edge and phase error
    assign pulse_edge = pulse_prev_r && !i_disk_pulse_in_n;
    assign half   = (phase_r < `FDS_HALF_POS) ? FDS_HALF_CLOCK
                                              : FDS_HALF_DATA;
    assign center = (half == FDS_HALF_DATA) ? `FDS_DATA_CENTER
                                            : `FDS_CLK_CENTER;
    assign err      = {1'b0, phase_r} - {1'b0, center};
    assign err_half = {err[5], err[5:1]};
    assign err_late  = !err[5] && (err != 6'h00);
    assign err_early = err[5];

    // short-term: half the error, saturated, for the current cell only
    assign st_meas = (err_half[5] && (err_half < 6'h3e)) ? `FDS_ST_MIN :
                     (!err_half[5] && (err_half > 6'h01)) ? `FDS_ST_MAX :
                     err_half[2:0];

    ////////////////////////////////////////////////////////////////////////
    // cell length from both correctors, clamped
    assign len_raw = `FDS_PERIOD_NOM
                   + {{3{lt_r[2]}}, lt_r}
                   + {{3{st_r[2]}}, st_r};
    assign len = (len_raw < `FDS_PERIOD_MIN) ? `FDS_PERIOD_MIN :
                 (len_raw > `FDS_PERIOD_MAX) ? `FDS_PERIOD_MAX :
                 len_raw;
    assign cell_end  = int_tick && ({1'b0, phase_r} >= len - 6'h01);
    assign phase_nxt = cell_end ? 5'h00 :
                       int_tick ? phase_r + 5'h01 : phase_r;

    // short-term value: a new pulse wins over the end-of-cell clear
    assign st_nxt = pulse_edge ? st_meas :
                    cell_end ? 3'h0 : st_r;

    ////////////////////////////////////////////////////////////////////////
    // long-term drift tracker, independent of the short-term value
    assign acc_up  = pulse_edge && err_late && (acc_r == `FDS_ACC_HI);
    assign acc_dn  = pulse_edge && err_early && (acc_r == `FDS_ACC_LO);
    assign acc_nxt = (acc_up || acc_dn) ? 3'h0 :
                     (pulse_edge && err_late) ? acc_r + 3'h1 :
                     (pulse_edge && err_early) ? acc_r - 3'h1 :
                     acc_r;
    assign lt_nxt  = (acc_up && (lt_r != `FDS_LT_MAX)) ? lt_r + 3'h1 :
                     (acc_dn && (lt_r != `FDS_LT_MIN)) ? lt_r - 3'h1 :
                     lt_r;

    ////////////////////////////////////////////////////////////////////////
    // state registers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ref_prev_r   <= 1'b0;
            pulse_prev_r <= 1'b1;
            phase_r      <= 5'h00;
            st_r         <= 3'h0;
            lt_r         <= 3'h0;
            acc_r        <= 3'h0;
        end else begin
            ref_prev_r   <= i_reference_clock_in;
            pulse_prev_r <= i_disk_pulse_in_n;
            phase_r      <= phase_nxt;
            st_r         <= st_nxt;
            lt_r         <= lt_nxt;
            acc_r        <= acc_nxt;
        end
    end

    // data flag: a data-half pulse on the last tick still counts
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            data_flag_r <= 1'b0;
            sdata_r     <= 1'b0;
        end else if (cell_end) begin
            data_flag_r <= 1'b0;
            sdata_r     <= data_flag_r
                        || (pulse_edge && half == FDS_HALF_DATA);
        end else if (pulse_edge && half == FDS_HALF_DATA) begin
            data_flag_r <= 1'b1;
        end
    end

    // recovered clock high through the clock half of each cell
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rclk_r <= 1'b0;
        end else begin
            rclk_r <= (phase_nxt < `FDS_HALF_POS);
        end
    end

    assign o_recovered_clock_out = rclk_r;
    assign o_separated_data_out  = sdata_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [5:0] cell_ticks_r;
    logic       had_pulse_r;
    logic       primed_r;
    logic       data_hit_r;
    logic       data_now;

    // data-half pulse edge in the current cycle
    assign data_now = pulse_edge && (phase_r >= `FDS_HALF_POS);

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cell_ticks_r <= 6'h00;
            had_pulse_r  <= 1'b0;
            primed_r     <= 1'b0;
            data_hit_r   <= 1'b0;
        end else if (cell_end) begin
            cell_ticks_r <= 6'h00;
            had_pulse_r  <= pulse_edge;
            primed_r     <= 1'b1;
            data_hit_r   <= 1'b0;
        end else begin
            cell_ticks_r <= cell_ticks_r + {5'h00, int_tick};
            had_pulse_r  <= had_pulse_r || pulse_edge;
            data_hit_r   <= data_hit_r || data_now;
        end
    end

    sequence s_quiet_cell_end;
        cell_end && !had_pulse_r && !pulse_edge && (lt_r == 3'h0);
    endsequence

    sequence s_data_cell_end;
        cell_end && (data_hit_r || data_now);
    endsequence

    sequence s_empty_cell_end;
        cell_end && primed_r && !data_hit_r && !data_now;
    endsequence

    a_period_min: assert property (@(posedge i_clk)
        disable iff (i_reset)
        (cell_end && primed_r) |-> (cell_ticks_r >= 6'h0b))
        else $error("recovered period shorter than 12 internal ticks");

    a_period_max: assert property (@(posedge i_clk)
        disable iff (i_reset)
        (cell_end && primed_r) |-> (cell_ticks_r <= 6'h15))
        else $error("recovered period longer than 22 internal ticks");

    a_period_nom: assert property (@(posedge i_clk)
        disable iff (i_reset)
        (s_quiet_cell_end and primed_r) |-> (cell_ticks_r == 6'h0f))
        else $error("uncorrected period is not 16 internal ticks");

    a_data_out: assert property (@(posedge i_clk)
        disable iff (i_reset)
        s_data_cell_end |=> o_separated_data_out)
        else $error("data-half pulse did not set separated data");

    a_data_clear: assert property (@(posedge i_clk)
        disable iff (i_reset)
        s_empty_cell_end |=> !o_separated_data_out)
        else $error("separated data set without a data-half pulse");

    a_clk_rise: assert property (@(posedge i_clk)
        disable iff (i_reset)
        cell_end |=> o_recovered_clock_out)
        else $error("recovered clock not high at cell start");

    a_clk_fall: assert property (@(posedge i_clk)
        disable iff (i_reset)
        (int_tick && phase_r == 5'h07 && !cell_end)
            |=> !o_recovered_clock_out ##1 (phase_r == 5'h08))
        else $error("recovered clock did not fall at half cell");

    a_short_term: assert property (@(posedge i_clk)
        disable iff (i_reset)
        (pulse_edge && phase_r == 5'h0c) |=> (st_r == 3'h0))
        else $error("centred pulse changed the short-term value");

    a_long_term: assert property (@(posedge i_clk)
        disable iff (i_reset)
        !pulse_edge |=> $stable(lt_r) && $stable(acc_r))
        else $error("long-term corrector moved without a pulse");

endmodule
`default_nettype wire

/* src/fds_defs.svh */
// fds_defs.svh: constants of the floppy data separator
`ifndef FDS_DEFS_SVH
`define FDS_DEFS_SVH

// divider select codes, upper bit first
`define FDS_DIV_BY1        2'h0
`define FDS_DIV_BY2        2'h1
`define FDS_DIV_BY4        2'h2
`define FDS_DIV_BY8        2'h3
// divider terminal masks (ratio minus one)
`define FDS_MASK_BY1       3'h0
`define FDS_MASK_BY2       3'h1
`define FDS_MASK_BY4       3'h3
`define FDS_MASK_BY8       3'h7

// bit cell length in internal clock ticks
`define FDS_PERIOD_NOM     6'h10
`define FDS_PERIOD_MIN     6'h0c
`define FDS_PERIOD_MAX     6'h16
// boundary between clock half and data half of a cell
`define FDS_HALF_POS       5'h08
// expected pulse positions inside a cell
`define FDS_CLK_CENTER     5'h04
`define FDS_DATA_CENTER    5'h0c

// short-term correction limits (3-bit two's complement)
`define FDS_ST_MAX         3'h1
`define FDS_ST_MIN         3'h6
// long-term correction limits (3-bit two's complement)
`define FDS_LT_MAX         3'h3
`define FDS_LT_MIN         3'h5
// drift accumulator thresholds (3-bit two's complement)
`define FDS_ACC_HI         3'h3
`define FDS_ACC_LO         3'h4

`endif

/* src/fds_pkg.sv */
// fds_pkg.sv: types of the floppy data separator
package fds_pkg;

    typedef logic [4:0] fds_phase_t;
    typedef logic [5:0] fds_len_t;
    typedef logic [2:0] fds_corr_t;

    // which half of the bit cell a pulse lands in
    typedef enum logic [1:0] {
        FDS_HALF_CLOCK = 2'b01,
        FDS_HALF_DATA  = 2'b10
    } fds_half_e;

endpackage

/* src/fds_divider.sv */
// fds_divider.sv: reference clock divider forming the internal tick
`timescale 1ns/1ps
`default_nettype none
`include "fds_defs.svh"

module fds_divider
    import fds_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_ref_tick,
    input  wire logic [1:0] i_div_sel,
    output logic            o_int_tick
);

    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    logic [2:0] mask;
    logic       wrap;

    ////////////////////////////////////////////////////////////////////////
    // ratio decode and terminal count
    assign mask = (i_div_sel == `FDS_DIV_BY1) ? `FDS_MASK_BY1 :
                  (i_div_sel == `FDS_DIV_BY2) ? `FDS_MASK_BY2 :
                  (i_div_sel == `FDS_DIV_BY4) ? `FDS_MASK_BY4 :
                                                `FDS_MASK_BY8;
    assign wrap       = ((cnt_r & mask) == mask);
    assign o_int_tick = i_ref_tick && wrap;
    assign cnt_nxt    = (!i_ref_tick) ? cnt_r :
                        wrap ? 3'h0 : cnt_r + 3'h1;

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks: reference ticks per internal tick do not exceed the ratio
    logic [3:0] seen_r;
    logic       first_r;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            seen_r  <= 4'h0;
            first_r <= 1'b1;
        end else if (o_int_tick) begin
            seen_r  <= 4'h0;
            first_r <= 1'b0;
        end else if (i_ref_tick) begin
            seen_r  <= seen_r + 4'h1;
        end
    end

    a_div_ratio: assert property (@(posedge i_clk)
        disable iff (i_reset)
        (o_int_tick && !first_r && $stable(i_div_sel))
            |-> ({1'b0, seen_r} <= {2'b00, mask}))
        else $error("internal tick came late for the selected ratio");

    a_div_tick_src: assert property (@(posedge i_clk)
        disable iff (i_reset)
        o_int_tick |-> i_ref_tick)
        else $error("internal tick without a reference tick");

endmodule
`default_nettype wire

/* test/fds_drive_model.sv */
// fds_drive_model.sv: drive and reference oscillator model
`timescale 1ns/1ps
`default_nettype none

module fds_drive_model #(
    parameter int REF_HALF = 7
) (
    input  wire logic i_clk,
    input  wire logic i_pulse_req,
    output var  logic o_ref,
    output var  logic o_pulse_n
);
    int ref_cnt;
    int low_cnt;

    initial begin
        o_ref     = 1'b0;
        o_pulse_n = 1'b1;
        ref_cnt   = 0;
        low_cnt   = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // 14 cycles per reference period, about 7.1 MHz
    always @(negedge i_clk) begin
        ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
        if (ref_cnt == REF_HALF - 1) o_ref <= ~o_ref;
    end

    ////////////////////////////////////////////////////////////////////////
    // each pulse is active low for 0.2 us, idle level high
    always @(negedge i_clk) begin
        if (i_pulse_req && low_cnt == 0) begin
            o_pulse_n <= 1'b0;
            low_cnt   <= 20;
        end else if (low_cnt > 1) begin
            low_cnt <= low_cnt - 1;
        end else if (low_cnt == 1) begin
            o_pulse_n <= 1'b1;
            low_cnt   <= 0;
        end
    end
endmodule

`default_nettype wire

/* test/test_floppy_data_separator.sv */
// test_floppy_data_separator.sv: self-checking bench of the separator
`timescale 1ns/1ps
`default_nettype none

module test_floppy_data_separator;
    localparam int HALF = 7;
    localparam int TICK = 2 * HALF;

    logic i_clk;
    logic i_reset;
    logic sel0;
    logic sel1;
    logic req;
    wire  ref_clk;
    wire  pulse_n;
    wire  rclk;
    wire  sdata;
    int   error_cnt;
    int   num_checks;

    fds_top u_fds_top (
        .i_clk                 (i_clk),
        .i_reset               (i_reset),
        .i_reference_clock_in  (ref_clk),
        .i_divider_select_0    (sel0),
        .i_divider_select_1    (sel1),
        .i_disk_pulse_in_n     (pulse_n),
        .o_recovered_clock_out (rclk),
        .o_separated_data_out  (sdata)
    );

    fds_drive_model #(.REF_HALF(HALF)) u_fds_drive_model (
        .i_clk       (i_clk),
        .i_pulse_req (req),
        .o_ref       (ref_clk),
        .o_pulse_n   (pulse_n)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    // cycles to the next clock rise, and high cycles within that span
    task automatic wait_rise(output int n, output int h);
        logic prev;
        prev = rclk;
        n = 0;
        h = 1;
        while (1) begin
            @(negedge i_clk);
            n++;
            if (rclk === 1'b1 && prev !== 1'b1) break;
            if (rclk === 1'b1) h++;
            prev = rclk;
            if (n > 4000) begin
                check(1'b0, "no recovered clock rise");
                tally_and_finish();
            end
        end
    endtask

    // pulse near the middle of tick ph, counted from the clock rise
    // used: negedges spent here, to add to the following wait_rise count
    task automatic pulse_at(input int ph, output int used);
        used = ph * TICK + HALF - 2;
        repeat (ph * TICK + HALF - 3) @(negedge i_clk);
        req <= 1'b1;
        @(negedge i_clk);
        req <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_nominal();
        int n;
        int h;
        // the cell cut by reset release is not a full period
        wait_rise(n, h);
        wait_rise(n, h);
        wait_rise(n, h);
        check(n == 16 * TICK, "nominal period");
        check(h == 8 * TICK, "clock half width");
        $display("t_nominal done");
    endtask

    task automatic t_divide();
        int n;
        int h;
        for (int s = 0; s < 4; s++) begin
            {sel1, sel0} = s[1:0];
            wait_rise(n, h);
            wait_rise(n, h);
            wait_rise(n, h);
            check(n == 16 * TICK * (1 << s), "divided period");
        end
        {sel1, sel0} = 2'h0;
        wait_rise(n, h);
        $display("t_divide done");
    endtask

    task automatic t_data();
        int n;
        int h;
        int u;
        wait_rise(n, h);
        pulse_at(12, u);
        wait_rise(n, h);
        check(n + u == 16 * TICK, "centred pulse moved cell");
        repeat (3) @(negedge i_clk);
        check(sdata === 1'b1, "data half pulse lost");
        pulse_at(4, u);
        wait_rise(n, h);
        repeat (3) @(negedge i_clk);
        check(sdata === 1'b0, "clock half pulse as data");
        $display("t_data done");
    endtask

    task automatic t_correct();
        int n;
        int h;
        int mx;
        int mn;
        int u;
        mx = 0;
        mn = 9999;
        wait_rise(n, h);
        repeat (8) begin
            pulse_at(15, u);
            wait_rise(n, h);
            if (n + u > mx) mx = n + u;
        end
        check(mx > 16 * TICK, "late pulses no stretch");
        check(mx <= 22 * TICK, "period above limit");
        wait_rise(n, h);
        check(n > 16 * TICK, "long-term drift lost");
        repeat (12) begin
            pulse_at(8, u);
            wait_rise(n, h);
            if (n + u < mn) mn = n + u;
        end
        check(mn < 16 * TICK, "early pulses no shrink");
        check(mn >= 12 * TICK, "period below limit");
        $display("t_correct done");
    endtask

    initial begin
        i_reset    = 1'b1;
        sel0       = 1'b0;
        sel1       = 1'b0;
        req        = 1'b0;
        error_cnt  = 0;
        num_checks = 0;
        repeat (6) @(negedge i_clk);
        i_reset = 1'b0;
        t_nominal();
        t_divide();
        t_data();
        t_correct();
        tally_and_finish();
    end
endmodule

`default_nettype wire
